// >>> verification/dual_cmp_ctrl_tb.sv
/*
 Self-checking bench for the dual comparator control logic.
 Assumes the cmp_pkg register map and an AXI4-Lite slave on aclk.
*/
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; \
    if ((got) !== (ex)) begin bad_count++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module testbench;
import cmp_pkg::*;
logic aclk, aresetn;
logic [7:0] awaddr, araddr;
logic awvalid, awready, wvalid, wready, bvalid, bready;
logic arvalid, arready, rvalid, rready;
logic [31:0] wdata, rdata, rv;
logic [1:0] bresp, rresp, resp;
logic raw_compare_1, raw_compare_2, first_quarter_phase, sleep_mode;
logic [1:0] cmp_enable_bit, noninv_ref_select, speed_power_select;
logic [1:0] inv_input_select_1, inv_input_select_2;
logic shared_output_pin_ff, shared_output_pin_oe_ff;
logic irq_request_ff, wake_ff;
int bad_count, samples_checked;

dual_cmp_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .raw_compare_1(raw_compare_1),
    .raw_compare_2(raw_compare_2),
    .first_quarter_phase(first_quarter_phase), .sleep_mode(sleep_mode),
    .cmp_enable_bit(cmp_enable_bit), .noninv_ref_select(noninv_ref_select),
    .speed_power_select(speed_power_select),
    .inv_input_select_1(inv_input_select_1),
    .inv_input_select_2(inv_input_select_2),
    .shared_output_pin_ff(shared_output_pin_ff),
    .shared_output_pin_oe_ff(shared_output_pin_oe_ff),
    .irq_request_ff(irq_request_ff), .wake_ff(wake_ff));

always #5 aclk = ~aclk;

task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ad, dd;
    ad = 0;
    dd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    // Address and data are released independently as each is taken
    while (!(ad && dd)) begin
        @(posedge aclk);
        if (!ad && awready) begin
            ad = 1;
            awvalid <= 0;
        end
        if (!dd && wready) begin
            dd = 1;
            wvalid <= 0;
        end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 0;
    resp = bresp;
endtask

task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rready <= 0;
    rv = rdata;
    resp = rresp;
endtask

// Each pulse is one instruction cycle; trailing edges let flags settle
task automatic pulse(input int n);
    repeat (n) begin
        @(posedge aclk);
        first_quarter_phase <= 1;
        @(posedge aclk);
        first_quarter_phase <= 0;
    end
    repeat (3) @(posedge aclk);
endtask

task automatic t_reset;
    rd(OFS_CTRL1);
    `CHK("ctrl1 reset", 32'h00000008, rv)
    `CHK("speed reset", 2'h3, speed_power_select)
    `CHK("enable reset", 2'h0, cmp_enable_bit)
    rd(OFS_PORT);
    `CHK("port reset", 32'h00000001, rv)
    `CHK("pin oe reset", 1'b0, shared_output_pin_oe_ff)
    rd(8'h1c);
    `CHK("unmapped rresp", RESP_SLVERR, resp)
    `CHK("unmapped rdata", 32'h0, rv)
endtask

task automatic t_controls;
    wr(OFS_CTRL1, 32'h86);
    `CHK("enable1", 1'b1, cmp_enable_bit[0])
    `CHK("inv sel1", 2'h2, inv_input_select_1)
    `CHK("ref sel", 2'h1, noninv_ref_select)
    `CHK("speed low", 2'h2, speed_power_select)
    wr(OFS_CTRL2, 32'h8b);
    `CHK("inv sel2", 2'h3, inv_input_select_2)
    `CHK("enable both", 2'h3, cmp_enable_bit)
    wr(8'h1c, 32'hff);
    `CHK("unmapped bresp", RESP_SLVERR, resp)
    wr(OFS_CTRL2, 32'h0b);
    raw_compare_2 <= 1;
    pulse(1);
    `CHK("enable off", 1'b0, cmp_enable_bit[1])
    rd(OFS_CTRL2);
    `CHK("disabled result", 32'h0b, rv)
endtask

task automatic t_result;
    raw_compare_1 <= 1;
    pulse(1);
    rd(OFS_CTRL1);
    `CHK("result high", 32'hc6, rv)
    rd(OFS_SHARED);
    `CHK("mirror", 32'h2, rv)
    raw_compare_1 <= 0;
    repeat (4) @(posedge aclk);
    rd(OFS_CTRL1);
    `CHK("result held", 32'hc6, rv)
    wr(OFS_CTRL1, 32'h96);
    pulse(1);
    rd(OFS_CTRL1);
    `CHK("inverted", 32'hd6, rv)
    wr(OFS_CTRL1, 32'h86);
    pulse(1);
endtask

task automatic t_flag;
    rd(OFS_CTRL1);
    wr(OFS_FLAGS, 32'h0);
    raw_compare_1 <= 1;
    pulse(2);
    rd(OFS_FLAGS);
    `CHK("flag on change", 32'h1, rv)
    wr(OFS_FLAGS, 32'h0);
    pulse(1);
    rd(OFS_FLAGS);
    `CHK("no level reflag", 32'h0, rv)
    raw_compare_1 <= 0;
    pulse(2);
    rd(OFS_FLAGS);
    `CHK("return uncleared", 32'h0, rv)
    raw_compare_1 <= 1;
    pulse(2);
    rd(OFS_CTRL1);
    wr(OFS_FLAGS, 32'h0);
    raw_compare_1 <= 0;
    pulse(2);
    rd(OFS_FLAGS);
    `CHK("return cleared", 32'h1, rv)
    wr(OFS_FLAGS, 32'h0);
    wr(OFS_CTRL1, 32'ha6);
    raw_compare_1 <= 1;
    pulse(2);
    rd(OFS_FLAGS);
    `CHK("write reloads", 32'h1, rv)
    wr(OFS_FLAGS, 32'h0);
    rd(OFS_CTRL1);
    raw_compare_1 <= 0;
    pulse(1);
    rd(OFS_FLAGS);
    `CHK("flag in one phase", 32'h1, rv)
endtask

task automatic t_irq;
    wr(OFS_IRQEN, 32'h1);
    wr(OFS_IRQCTL, 32'hc0);
    repeat (2) @(posedge aclk);
    `CHK("irq all on", 1'b1, irq_request_ff)
    wr(OFS_IRQCTL, 32'h40);
    repeat (2) @(posedge aclk);
    `CHK("irq no global", 1'b0, irq_request_ff)
    rd(OFS_FLAGS);
    `CHK("flag kept", 32'h1, rv)
    sleep_mode <= 1;
    repeat (2) @(posedge aclk);
    `CHK("wake", 1'b1, wake_ff)
    wr(OFS_FLAGS, 32'h2);
    rd(OFS_FLAGS);
    `CHK("software set", 32'h2, rv)
    `CHK("wake cleared", 1'b0, wake_ff)
    wr(OFS_FLAGS, 32'h0);
    sleep_mode <= 0;
endtask

task automatic t_pin;
    wr(OFS_PORT, 32'h2);
    wr(OFS_CTRL1, 32'h86);
    wr(OFS_CTRL2, 32'h0b);
    raw_compare_1 <= 0;
    pulse(1);
    `CHK("pin driven", 1'b1, shared_output_pin_oe_ff)
    `CHK("pin port latch", 1'b1, shared_output_pin_ff)
    wr(OFS_CTRL1, 32'ha6);
    repeat (2) @(posedge aclk);
    `CHK("pin comp1", 1'b0, shared_output_pin_ff)
    wr(OFS_CTRL2, 32'hab);
    pulse(1);
    `CHK("pin comp2 wins", 1'b1, shared_output_pin_ff)
    wr(OFS_CTRL2, 32'h3b);
    pulse(1);
    `CHK("pin disabled", 1'b0, shared_output_pin_ff)
    wr(OFS_PORT, 32'h3);
    repeat (2) @(posedge aclk);
    `CHK("pin input", 1'b0, shared_output_pin_oe_ff)
endtask

task automatic summarize;
    if (bad_count == 0 && samples_checked > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask

// Whole sequence needs a few hundred cycles; this cuts a hung wait
initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    summarize();
end

initial begin
    aclk = 0;
    aresetn = 0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {raw_compare_1, raw_compare_2, first_quarter_phase, sleep_mode} = '0;
    bad_count = 0;
    samples_checked = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_controls();
    t_result();
    t_flag();
    t_irq();
    t_pin();
    summarize();
end
endmodule

// >>> verilog/cmp_channel.sv
/*
 One comparator channel: result register with polarity, the two
 mismatch latches and the edge-set interrupt flag.
 Assumes a one-cycle first_quarter_phase pulse per instruction cycle
 and a one-cycle ctrl_access pulse for each read or write of the
 channel's control register.
*/
`timescale 1ns/10ps
module cmp_channel (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Analog side and controls
    input wire logic raw_compare,
    input wire logic enable,
    input wire logic invert,
    input wire logic first_quarter_phase,
    // Software access
    input wire logic ctrl_access,
    input wire logic flag_write,
    input wire logic flag_wdata,
    // State
    output logic result_ff,
    output logic mismatch,
    output logic irq_flag_ff
);
    import cmp_pkg::*;

    logic nxt_result;
    logic read_latch_ff;
    logic phase_latch_ff;
    logic mismatch_prev_ff;
    logic nxt_flag;

    // Off comparator reads low before polarity, so invert sets the level
    assign nxt_result = (raw_compare & enable) ^ invert;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_ff <= 1'b0;
        end else if (first_quarter_phase) begin
            result_ff <= nxt_result;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            read_latch_ff <= 1'b0;
        end else if (ctrl_access) begin
            read_latch_ff <= result_ff;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_latch_ff <= 1'b0;
        end else if (first_quarter_phase) begin
            // Takes what the result takes, so a read between two
            // phases cannot fake a mismatch
            phase_latch_ff <= nxt_result;
        end
    end

    assign mismatch = read_latch_ff ^ phase_latch_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mismatch_prev_ff <= 1'b0;
        end else begin
            mismatch_prev_ff <= mismatch;
        end
    end

    // Edge, not level: a cleared flag stays clear while mismatch lasts
    always_comb begin
        nxt_flag = flag_write ? flag_wdata : irq_flag_ff;
        if (mismatch && !mismatch_prev_ff) begin
            nxt_flag = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_flag_ff <= 1'b0;
        end else begin
            irq_flag_ff <= nxt_flag;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    flag_edge_a: assert property (
        mismatch && !mismatch_prev_ff |=> irq_flag_ff)
        else $error("mismatch edge did not set flag");
    read_latch_a: assert property (
        ctrl_access |=> read_latch_ff == $past(result_ff))
        else $error("read latch missed result");
    phase_latch_a: assert property (
        first_quarter_phase |=>
        phase_latch_ff == ($past(raw_compare & enable) ^ $past(invert)))
        else $error("phase latch missed result");
    off_level_a: assert property (
        first_quarter_phase && !enable |=> result_ff == $past(invert))
        else $error("disabled result not forced");
    flag_write_a: assert property (
        flag_write && flag_wdata |=> irq_flag_ff)
        else $error("software flag set lost");
    flag_rise_c: cover property (mismatch ##1 irq_flag_ff);
endmodule

// >>> verilog/cmp_pkg.sv
/*
 Constants for the dual comparator control logic: register byte
 offsets, field positions, reset values and bus response codes.
 Assumes a 32-bit AXI4-Lite bus with registers in the low byte.
*/
package cmp_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL1 = 8'h00;
    localparam logic [7:0] OFS_CTRL2 = 8'h04;
    localparam logic [7:0] OFS_SHARED = 8'h08;
    localparam logic [7:0] OFS_FLAGS = 8'h0c;
    localparam logic [7:0] OFS_IRQEN = 8'h10;
    localparam logic [7:0] OFS_IRQCTL = 8'h14;
    localparam logic [7:0] OFS_PORT = 8'h18;
    // Fields of each cmp_control_reg
    localparam int EN_BIT = 7;
    localparam int RES_BIT = 6;
    localparam int OE_BIT = 5;
    localparam int POL_BIT = 4;
    localparam int SP_BIT = 3;
    localparam int REF_BIT = 2;
    localparam int CH_LSB = 0;
    localparam logic [7:0] CTRL_RESET = 8'h08;
    localparam logic [7:0] CTRL_WMASK = 8'hbf;
    // shared_cmp_control_reg mirror bits
    localparam int MIRROR1_BIT = 1;
    localparam int MIRROR2_BIT = 0;
    // Flag and enable bits in the peripheral flag/enable registers
    localparam int FLAG1_BIT = 0;
    localparam int FLAG2_BIT = 1;
    localparam logic [1:0] FLAGS_RESET = 2'h0;
    localparam logic [1:0] IRQEN_RESET = 2'h0;
    // irq_control_reg
    localparam int GIE_BIT = 7;
    localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
    localparam logic [1:0] IRQCTL_RESET = 2'h0;
    // Port control: direction (1 = input) and data latch
    localparam int DIR_BIT = 0;
    localparam int LATCH_BIT = 1;
    localparam logic [1:0] PORT_RESET = 2'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> verilog/dual_cmp_ctrl.sv
/*
 Two-comparator control, pin priority, mismatch flags and wake logic.
 Assumes inputs synchronous to aclk and raw results as logic levels.
*/
`timescale 1ns/10ps
// What this block does
// - Enable bit turns a comparator on; clear turns it off.
// - Two-bit field picks one of four inverting inputs.
// - Reference bit picks internal reference or pin for plus input.
// - Result drives pin only with output enable, enable, and output dir.
// - Pin: port when no enables, comparator 1, comparator 2 wins.
// - Output enable overrides port latch regardless of comparator enable.
// - Internal result registered once per instruction cycle.
// - Result high when plus input exceeds minus; invert bit flips it.
// - Speed bit resets to 1 normal speed; 0 selects low power.
// - Result readable in own control and shared mirror register.
// - First latch captures result on every control register read.
// - Second latch samples each first phase; XOR gives mismatch.
// - Mismatch holds until a read or the result returns.
// - A control register write also clears the mismatch.
// - Interrupts behave the same whatever the output enable.
// - Flag set on mismatch rising edge, not level.
// - Return after clear raises interrupt; without clear it does not.
// - Software clears flag writing 0; writing 1 sets it.
// - Request needs flag, comparator, peripheral and global enables.
// - Reset returns control registers and comparators to off.
// - In sleep, a flagged enabled change wakes the device.
module dual_cmp_ctrl (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [cmp_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // AXI4-Lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read address
    input wire logic [cmp_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // AXI4-Lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Analog comparator results and timing
    input wire logic raw_compare_1,
    input wire logic raw_compare_2,
    input wire logic first_quarter_phase,
    input wire logic sleep_mode,
    // Analog controls
    output logic [1:0] cmp_enable_bit,
    output logic [1:0] noninv_ref_select,
    output logic [1:0] speed_power_select,
    output logic [1:0] inv_input_select_1,
    output logic [1:0] inv_input_select_2,
    // Shared output pin
    output logic shared_output_pin_ff,
    output logic shared_output_pin_oe_ff,
    // Interrupt and wake
    output logic irq_request_ff,
    output logic wake_ff
);
    import cmp_pkg::*;

    logic [7:0] ctrl1_ff;
    logic [7:0] ctrl2_ff;
    logic [1:0] irq_en_ff;
    logic [1:0] irq_ctl_ff;
    logic [1:0] port_ff;
    logic awready_ff;
    logic wready_ff;
    logic aw_hold_ff;
    logic w_hold_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [7:0] wdata_ff;
    logic wlane_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic do_write;
    logic do_read;
    logic wr_ok;
    logic [1:0] result;
    logic [1:0] mismatch;
    logic [1:0] flags;
    logic [1:0] ctrl_access;
    logic flag_write;
    logic [1:0] pending;
    logic nxt_pin;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == OFS_CTRL1) || (a == OFS_CTRL2) ||
            (a == OFS_SHARED) || (a == OFS_FLAGS) ||
            (a == OFS_IRQEN) || (a == OFS_IRQCTL) || (a == OFS_PORT);
    endfunction

    // Control register image with the live result in its read-only bit
    function automatic logic [7:0] ctrl_view(input logic [7:0] c,
                                             input logic r);
        ctrl_view = c;
        ctrl_view[RES_BIT] = r;
    endfunction

    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;

    assign cmp_enable_bit = {ctrl2_ff[EN_BIT], ctrl1_ff[EN_BIT]};
    assign noninv_ref_select = {ctrl2_ff[REF_BIT], ctrl1_ff[REF_BIT]};
    assign speed_power_select = {ctrl2_ff[SP_BIT], ctrl1_ff[SP_BIT]};
    assign inv_input_select_1 = ctrl1_ff[CH_LSB+1:CH_LSB];
    assign inv_input_select_2 = ctrl2_ff[CH_LSB+1:CH_LSB];

    // Write channel: address and data are taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b0;
        end else if (awvalid && awready_ff) begin
            awready_ff <= 1'b0;
        end else if (!aw_hold_ff && !bvalid_ff) begin
            awready_ff <= 1'b1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_ff <= 1'b0;
        end else if (wvalid && wready_ff) begin
            wready_ff <= 1'b0;
        end else if (!w_hold_ff && !bvalid_ff) begin
            wready_ff <= 1'b1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            awaddr_ff <= '0;
        end else if (awvalid && awready_ff) begin
            aw_hold_ff <= 1'b1;
            awaddr_ff <= awaddr;
        end else if (do_write) begin
            aw_hold_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_ff <= 1'b0;
            wdata_ff <= 8'h00;
            wlane_ff <= 1'b0;
        end else if (wvalid && wready_ff) begin
            w_hold_ff <= 1'b1;
            wdata_ff <= wdata[7:0];
            wlane_ff <= wstrb[0];
        end else if (do_write) begin
            w_hold_ff <= 1'b0;
        end
    end

    assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
    assign wr_ok = do_write && wlane_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= is_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Register file; the result bit is never stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl1_ff <= CTRL_RESET;
        end else if (wr_ok && awaddr_ff == OFS_CTRL1) begin
            ctrl1_ff <= wdata_ff & CTRL_WMASK;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl2_ff <= CTRL_RESET;
        end else if (wr_ok && awaddr_ff == OFS_CTRL2) begin
            ctrl2_ff <= wdata_ff & CTRL_WMASK;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_en_ff <= IRQEN_RESET;
        end else if (wr_ok && awaddr_ff == OFS_IRQEN) begin
            irq_en_ff <= {wdata_ff[FLAG2_BIT], wdata_ff[FLAG1_BIT]};
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_ctl_ff <= IRQCTL_RESET;
        end else if (wr_ok && awaddr_ff == OFS_IRQCTL) begin
            irq_ctl_ff <= {wdata_ff[GIE_BIT], wdata_ff[PERIPHERAL_IRQ_ENABLE_BIT]};
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_ff <= PORT_RESET;
        end else if (wr_ok && awaddr_ff == OFS_PORT) begin
            port_ff <= {wdata_ff[LATCH_BIT], wdata_ff[DIR_BIT]};
        end
    end

    // Read channel: one read at a time, data registered
    assign do_read = arvalid && arready_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
        end else if (do_read) begin
            arready_ff <= 1'b0;
        end else if (!rvalid_ff) begin
            arready_ff <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= 32'h0000_0000;
        end else if (do_read) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata_ff <= 32'h0000_0000;
            case (araddr)
                OFS_CTRL1: rdata_ff[7:0] <= ctrl_view(ctrl1_ff, result[0]);
                OFS_CTRL2: rdata_ff[7:0] <= ctrl_view(ctrl2_ff, result[1]);
                OFS_SHARED: rdata_ff[MIRROR1_BIT:MIRROR2_BIT] <=
                    {result[0], result[1]};
                OFS_FLAGS: rdata_ff[FLAG2_BIT:FLAG1_BIT] <= flags;
                OFS_IRQEN: rdata_ff[FLAG2_BIT:FLAG1_BIT] <= irq_en_ff;
                OFS_IRQCTL: rdata_ff[GIE_BIT:PERIPHERAL_IRQ_ENABLE_BIT] <= irq_ctl_ff;
                OFS_PORT: rdata_ff[LATCH_BIT:DIR_BIT] <= port_ff;
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end else if (rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Any access reloads the read latch, since a write reads first
    assign ctrl_access[0] = (do_read && araddr == OFS_CTRL1) ||
        (do_write && awaddr_ff == OFS_CTRL1);
    assign ctrl_access[1] = (do_read && araddr == OFS_CTRL2) ||
        (do_write && awaddr_ff == OFS_CTRL2);
    assign flag_write = wr_ok && awaddr_ff == OFS_FLAGS;

    // Independent channels; the output enable plays no part here
    cmp_channel chan1 (
        .aclk(aclk), .aresetn(aresetn), .raw_compare(raw_compare_1),
        .enable(ctrl1_ff[EN_BIT]), .invert(ctrl1_ff[POL_BIT]),
        .first_quarter_phase(first_quarter_phase),
        .ctrl_access(ctrl_access[0]), .flag_write(flag_write),
        .flag_wdata(wdata_ff[FLAG1_BIT]), .result_ff(result[0]),
        .mismatch(mismatch[0]), .irq_flag_ff(flags[0])
    );
    cmp_channel chan2 (
        .aclk(aclk), .aresetn(aresetn), .raw_compare(raw_compare_2),
        .enable(ctrl2_ff[EN_BIT]), .invert(ctrl2_ff[POL_BIT]),
        .first_quarter_phase(first_quarter_phase),
        .ctrl_access(ctrl_access[1]), .flag_write(flag_write),
        .flag_wdata(wdata_ff[FLAG2_BIT]), .result_ff(result[1]),
        .mismatch(mismatch[1]), .irq_flag_ff(flags[1])
    );

    // Pin mux: comparator 2 has priority; a disabled one drives low
    always_comb begin
        if (ctrl2_ff[OE_BIT]) begin
            nxt_pin = ctrl2_ff[EN_BIT] & result[1];
        end else if (ctrl1_ff[OE_BIT]) begin
            nxt_pin = ctrl1_ff[EN_BIT] & result[0];
        end else begin
            nxt_pin = port_ff[LATCH_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shared_output_pin_ff <= 1'b0;
            shared_output_pin_oe_ff <= 1'b0;
        end else begin
            shared_output_pin_ff <= nxt_pin;
            shared_output_pin_oe_ff <= !port_ff[DIR_BIT];
        end
    end

    assign pending = flags & irq_en_ff;

    // Flags still set with enables clear; only the request and wake are gated
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_request_ff <= 1'b0;
            wake_ff <= 1'b0;
        end else begin
            irq_request_ff <= (|pending) & irq_ctl_ff[0] &
                irq_ctl_ff[1];
            wake_ff <= (|pending) & irq_ctl_ff[0] & sleep_mode;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    pin_priority_a: assert property (
        ctrl2_ff[OE_BIT] |=>
        shared_output_pin_ff == $past(ctrl2_ff[EN_BIT] & result[1]))
        else $error("comparator 2 lost pin priority");
    pin_port_a: assert property (
        !ctrl1_ff[OE_BIT] && !ctrl2_ff[OE_BIT] |=>
        shared_output_pin_ff == $past(port_ff[LATCH_BIT]))
        else $error("port latch not on pin");
    pin_drive_a: assert property (
        ##1 shared_output_pin_oe_ff == !$past(port_ff[DIR_BIT]))
        else $error("pin enable does not follow direction");
    irq_gate_a: assert property (
        irq_request_ff |->
        $past(|pending) && $past(irq_ctl_ff) == 2'h3)
        else $error("request without all enables");
    wake_gate_a: assert property (
        sleep_mode && (|pending) && irq_ctl_ff[0] |=> wake_ff)
        else $error("no wake on enabled change");
    reset_state_a: assert property (
        $rose(aresetn) |-> ctrl1_ff == CTRL_RESET &&
        ctrl2_ff == CTRL_RESET)
        else $error("control registers not at reset");
    read_answer_a: assert property (
        do_read && araddr == OFS_SHARED |=>
        rvalid_ff && rdata_ff[MIRROR2_BIT] == $past(result[1]))
        else $error("mirror bit wrong");
    write_answer_a: assert property (
        do_write |=> bvalid_ff [*1] ##0 !aw_hold_ff)
        else $error("write not answered");

    pin_c2_c: cover property (ctrl2_ff[OE_BIT] && result[1]);
    irq_c: cover property (irq_request_ff);
    wake_c: cover property (wake_ff);
endmodule
